// >>> hw/iosc_device.sv
// device end: answers i/o status reads, takes device writes and input disable
`timescale 1ns/1ps
// Notes on behaviour
// - read 4,0 returns ten input pins
// - each pin bit is one connector pin
// - set bit means on, sent as hex
// - read 6,0 returns communication input devices
// - input word low bits layout
// - input word bits 16 to 31
// - read c,0 returns seven output pins
// - output pin bits 0-6, rest unused
// - read 8,0 returns output device word
// - output word bits 0 to 15
// - output word bits 17 to 24
// - device states follow last written word
// - write 6,0 sets input devices per bit
// - master cannot turn off wired input
// - disable zeroes devices, analog, pulses
// - forced stop and limits never disabled
// - disable on 0,0 with key 1ea5
module iosc_device
(
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_rst_n,
    iosc_if.device                     link,
    input  wire logic [9:0]            i_ext_in_pins,
    input  wire logic [6:0]            i_ext_out_pins,
    input  wire logic [31:0]           i_ext_in_dev,
    input  wire logic [31:0]           i_out_dev,
    input  wire logic [15:0]           i_analog_in,
    input  wire logic                  i_pulse_in,
    output logic      [31:0]           o_eff_in_dev,
    output logic      [15:0]           o_eff_analog,
    output logic                       o_eff_pulse,
    output logic                       o_in_disabled
);
    // ==================================================
    // pin synchronisers
    logic [9:0]  in_pins_s1_r;
    logic [9:0]  in_pins_s2_r;
    logic [6:0]  out_pins_s1_r;
    logic [6:0]  out_pins_s2_r;
    logic [31:0] ext_dev_s1_r;
    logic [31:0] ext_dev_s2_r;
    logic        pulse_s1_r;
    logic        pulse_s2_r;
    logic [31:0] comm_dev_r;
    logic        in_dis_r;
    logic [31:0] raw_dev;
    logic [31:0] rd_word_nxt;
    logic        rd_hit;
    // input device word after disable gate
    logic [31:0] gated_dev;
    // decoded link requests
    logic        key_ok;
    logic        wr_cmd;
    logic        dis_cmd;
    logic        en_cmd;

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            in_pins_s1_r  <= '0;
            in_pins_s2_r  <= '0;
            out_pins_s1_r <= '0;
            out_pins_s2_r <= '0;
            ext_dev_s1_r  <= '0;
            ext_dev_s2_r  <= '0;
            pulse_s1_r    <= 1'b0;
            pulse_s2_r    <= 1'b0;
        end
        else
        begin
            in_pins_s1_r  <= i_ext_in_pins;
            in_pins_s2_r  <= in_pins_s1_r;
            out_pins_s1_r <= i_ext_out_pins;
            out_pins_s2_r <= out_pins_s1_r;
            ext_dev_s1_r  <= i_ext_in_dev;
            ext_dev_s2_r  <= ext_dev_s1_r;
            pulse_s1_r    <= i_pulse_in;
            pulse_s2_r    <= pulse_s1_r;
        end
    end

    // ==================================================
    // command decode, shared by state updates
    assign key_ok  = link.req_data[15:0] == iosc_pkg::DISABLE_KEY;
    assign wr_cmd  = link.req_valid && link.req_cmd == iosc_pkg::CMD_DEV_WRITE
                     && link.req_dnum == iosc_pkg::DN_COMM_IN_DEV;
    assign dis_cmd = link.req_valid && link.req_cmd == iosc_pkg::CMD_IO_DISABLE && key_ok
                     && link.req_dnum == iosc_pkg::DN_IN_DISABLE;
    assign en_cmd  = link.req_valid && link.req_cmd == iosc_pkg::CMD_IO_DISABLE && key_ok
                     && link.req_dnum == iosc_pkg::DN_IN_ENABLE;

    // ==================================================
    // communication input devices, last word wins
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
            comm_dev_r <= iosc_pkg::IN_DEV_RESET;
        else if (wr_cmd)
            comm_dev_r <= link.req_data & iosc_pkg::IN_DEV_USED_MASK;
    end

    // ==================================================
    // input disable state, a wrong key leaves it as it is
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
            in_dis_r <= iosc_pkg::IN_DIS_RESET;
        else if (dis_cmd)
            in_dis_r <= 1'b1;
        else if (en_cmd)
            in_dis_r <= 1'b0;
    end

    // ==================================================
    // effective inputs seen by the drive
    assign raw_dev = ext_dev_s2_r | comm_dev_r;

    // ==================================================
    // per-bit disable gate, exempt bits keep following their sources
    for (genvar gi = 0; gi < 32; gi++)
    begin : g_gate
        assign gated_dev[gi] = raw_dev[gi] && (iosc_pkg::IN_EXEMPT_MASK[gi] || !in_dis_r);
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            o_eff_in_dev  <= '0;
            o_eff_analog  <= '0;
            o_eff_pulse   <= 1'b0;
            o_in_disabled <= 1'b0;
        end
        else
        begin
            // disable is independent of the on/off word
            o_eff_in_dev  <= gated_dev;
            // analog reads as zero volts while disabled
            o_eff_analog  <= in_dis_r ? 16'h0000 : i_analog_in;
            o_eff_pulse   <= in_dis_r ? 1'b0 : pulse_s2_r;
            o_in_disabled <= in_dis_r;
        end
    end

    // ==================================================
    // read decode
    always_comb
    begin
        rd_word_nxt = 32'h0000_0000;
        rd_hit      = 1'b1;
        if (link.req_dnum == iosc_pkg::DN_EXT_IN_PINS)
            rd_word_nxt = {22'h000000, in_pins_s2_r};
        else if (link.req_dnum == iosc_pkg::DN_COMM_IN_DEV)
            rd_word_nxt = comm_dev_r & iosc_pkg::IN_DEV_USED_MASK;
        else if (link.req_dnum == iosc_pkg::DN_EXT_OUT_PINS)
            rd_word_nxt = {25'h0000000, out_pins_s2_r};
        else if (link.req_dnum == iosc_pkg::DN_OUT_DEV)
            rd_word_nxt = i_out_dev & iosc_pkg::OUT_DEV_USED_MASK;
        // any other data number is refused
        else
            rd_hit = 1'b0;
    end

    // ==================================================
    // answer register, one cycle after request
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            link.ans_valid <= 1'b0;
            link.ans_kind  <= iosc_pkg::IOSC_ANS_NONE;
            link.ans_data  <= '0;
        end
        else
        begin
            link.ans_valid <= link.req_valid;
            link.ans_data  <= '0;
            link.ans_kind  <= iosc_pkg::IOSC_ANS_NONE;
            if (link.req_valid)
            begin
                if (link.req_cmd == iosc_pkg::CMD_IO_READ && rd_hit)
                begin
                    link.ans_kind <= iosc_pkg::IOSC_ANS_DATA;
                    link.ans_data <= rd_word_nxt;
                end
                else if (link.req_cmd == iosc_pkg::CMD_DEV_WRITE
                         && link.req_dnum == iosc_pkg::DN_COMM_IN_DEV)
                    link.ans_kind <= iosc_pkg::IOSC_ANS_ACK;
                else if (link.req_cmd == iosc_pkg::CMD_IO_DISABLE
                         && link.req_data[15:0] == iosc_pkg::DISABLE_KEY
                         && (link.req_dnum == iosc_pkg::DN_IN_DISABLE
                             || link.req_dnum == iosc_pkg::DN_IN_ENABLE))
                    link.ans_kind <= iosc_pkg::IOSC_ANS_ACK;
                // unknown code or wrong key: error, no state change
                else
                    link.ans_kind <= iosc_pkg::IOSC_ANS_ERR;
            end
        end
    end
endmodule : iosc_device

// >>> hw/iosc_pkg.sv
// package: command codes, data numbers, bit positions and reset values for the i/o status command handler
package iosc_pkg;
    // ==================================================
    // command and data number codes
    localparam logic [7:0]  CMD_IO_READ      = 8'h12;
    localparam logic [7:0]  CMD_DEV_WRITE    = 8'h92;
    localparam logic [7:0]  CMD_IO_DISABLE   = 8'h90;
    localparam logic [7:0]  DN_EXT_IN_PINS   = 8'h40;
    localparam logic [7:0]  DN_COMM_IN_DEV   = 8'h60;
    localparam logic [7:0]  DN_EXT_OUT_PINS  = 8'hc0;
    localparam logic [7:0]  DN_OUT_DEV       = 8'h80;
    localparam logic [7:0]  DN_IN_DISABLE    = 8'h00;
    localparam logic [7:0]  DN_IN_ENABLE     = 8'h10;
    localparam logic [15:0] DISABLE_KEY      = 16'h1ea5;
    // ==================================================
    // field widths
    localparam int          EXT_IN_PINS_W    = 10;
    localparam int          EXT_OUT_PINS_W   = 7;
    // ==================================================
    // input device word bit positions
    localparam int          B_SERVO_ON       = 0;
    localparam int          B_FWD_LIMIT      = 1;
    localparam int          B_REV_LIMIT      = 2;
    localparam int          B_FORCED_STOP    = 16;
    // used bits of the input device word: 0-6, 10-12, 16-27, 29-31
    localparam logic [31:0] IN_DEV_USED_MASK = 32'hefff_1c7f;
    // exempt from disabling: forced stop and both stroke limits
    localparam logic [31:0] IN_EXEMPT_MASK   = 32'h0001_0006;
    // ==================================================
    // output device word: used bits 0,3,7,8,10,11,15,17-24
    localparam logic [31:0] OUT_DEV_USED_MASK = 32'h01fe_8d89;
    // ==================================================
    // register offsets of the master end
    localparam logic [11:0] OFS_CMD          = 12'h000;
    localparam logic [11:0] OFS_DATA         = 12'h004;
    localparam logic [11:0] OFS_STATUS       = 12'h008;
    localparam logic [11:0] OFS_ANSWER       = 12'h00c;
    // ==================================================
    // reset values
    localparam logic [31:0] IN_DEV_RESET     = 32'h0000_0000;
    localparam logic        IN_DIS_RESET     = 1'b0;
    // ==================================================
    // answer kinds
    typedef enum logic [1:0]
    {
        IOSC_ANS_NONE = 2'b00,
        IOSC_ANS_DATA = 2'b01,
        IOSC_ANS_ACK  = 2'b11,
        IOSC_ANS_ERR  = 2'b10
    } iosc_ans_t;
endpackage : iosc_pkg

// >>> hw/iosc_if.sv
// interface: command link between master end and device end
`timescale 1ns/1ps
interface iosc_if;
    logic                    req_valid;
    logic [7:0]              req_cmd;
    logic [7:0]              req_dnum;
    logic [31:0]             req_data;
    logic                    ans_valid;
    iosc_pkg::iosc_ans_t     ans_kind;
    logic [31:0]             ans_data;

    modport master
    (
        output req_valid,
        output req_cmd,
        output req_dnum,
        output req_data,
        input  ans_valid,
        input  ans_kind,
        input  ans_data
    );

    modport device
    (
        input  req_valid,
        input  req_cmd,
        input  req_dnum,
        input  req_data,
        output ans_valid,
        output ans_kind,
        output ans_data
    );
endinterface : iosc_if

// >>> hw/iosc_master.sv
// master end: takes orders over apb and issues commands on the link
`timescale 1ns/1ps
module iosc_master
(
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_rst_n,
    iosc_if.master                     link,
    input  wire logic                  i_psel,
    input  wire logic                  i_penable,
    input  wire logic                  i_pwrite,
    input  wire logic [11:0]           i_paddr,
    input  wire logic [31:0]           i_pwdata,
    output logic      [31:0]           o_prdata,
    output logic                       o_pready,
    output logic                       o_pslverr
);
    // ==================================================
    // register offsets
    localparam logic [11:0] OFS_CMD    = iosc_pkg::OFS_CMD;
    localparam logic [11:0] OFS_DATA   = iosc_pkg::OFS_DATA;
    localparam logic [11:0] OFS_STATUS = iosc_pkg::OFS_STATUS;
    localparam logic [11:0] OFS_ANSWER = iosc_pkg::OFS_ANSWER;

    logic [15:0]          cmd_r;
    logic [31:0]          data_r;
    logic [31:0]          answer_r;
    iosc_pkg::iosc_ans_t  kind_r;
    logic                 busy_r;
    logic                 done_r;
    logic                 wr_acc;
    logic                 go;

    assign wr_acc   = i_psel && i_penable && i_pwrite;
    assign go       = wr_acc && i_paddr == OFS_CMD && !busy_r;
    assign o_pready = 1'b1;

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
            data_r <= '0;
        else if (wr_acc && i_paddr == OFS_DATA)
            data_r <= i_pwdata;
    end

    // ==================================================
    // link request, one cycle pulse
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            cmd_r          <= '0;
            link.req_valid <= 1'b0;
            link.req_cmd   <= '0;
            link.req_dnum  <= '0;
            link.req_data  <= '0;
        end
        else
        begin
            link.req_valid <= go;
            if (go)
            begin
                cmd_r         <= i_pwdata[15:0];
                link.req_cmd  <= i_pwdata[15:8];
                link.req_dnum <= i_pwdata[7:0];
                link.req_data <= data_r;
            end
        end
    end

    // ==================================================
    // answer capture, done is sticky, new command clears it
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            busy_r   <= 1'b0;
            done_r   <= 1'b0;
            answer_r <= '0;
            kind_r   <= iosc_pkg::IOSC_ANS_NONE;
        end
        else if (link.ans_valid)
        begin
            busy_r   <= 1'b0;
            done_r   <= 1'b1;
            answer_r <= link.ans_data;
            kind_r   <= link.ans_kind;
        end
        else if (go)
        begin
            busy_r <= 1'b1;
            done_r <= 1'b0;
        end
    end

    // ==================================================
    // apb read and error
    always_comb
    begin
        o_prdata  = 32'h0000_0000;
        o_pslverr = 1'b0;
        if (i_paddr == OFS_CMD)
            o_prdata = {16'h0000, cmd_r};
        else if (i_paddr == OFS_DATA)
            o_prdata = data_r;
        else if (i_paddr == OFS_STATUS)
            o_prdata = {28'h0000000, kind_r, done_r, busy_r};
        else if (i_paddr == OFS_ANSWER)
            o_prdata = answer_r;
        else
            o_pslverr = i_psel && i_penable;
    end
endmodule : iosc_master

// >>> dv/iosc_link_asserts.sv
// checker: request and answer relations on the command link
`timescale 1ns/1ps
module iosc_link_asserts
(
    input  wire logic                i_sys_clk,
    input  wire logic                i_rst_n,
    input  wire logic                req_valid,
    input  wire logic [7:0]          req_cmd,
    input  wire logic [7:0]          req_dnum,
    input  wire logic [31:0]         req_data,
    input  wire logic                ans_valid,
    input  wire iosc_pkg::iosc_ans_t ans_kind,
    input  wire logic [31:0]         ans_data
);
    logic        wr_hit;
    logic [31:0] last_wr_r;

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);

    // ==========================================
    // last input device word written
    assign wr_hit = req_valid && req_cmd == 8'h92 && req_dnum == 8'h60;
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
            last_wr_r <= 32'h0000_0000;
        else if (wr_hit)
            last_wr_r <= req_data;
    end

    // ==========================================
    // sequences and properties
    sequence s_rd(logic [7:0] dn);
        req_valid && req_cmd == 8'h12 && req_dnum == dn;
    endsequence
    sequence s_dis(logic [15:0] key);
        req_valid && req_cmd == 8'h90 && req_dnum == 8'h00 && req_data[15:0] == key;
    endsequence
    sequence s_data;
        ans_valid && ans_kind == iosc_pkg::IOSC_ANS_DATA;
    endsequence

    property p_ans_lat;
        req_valid |=> ans_valid;
    endproperty
    property p_no_stray;
        !req_valid |=> !ans_valid;
    endproperty
    property p_in_pins;
        s_rd(8'h40) |=> s_data ##0 ans_data[31:10] == 22'h0;
    endproperty
    property p_out_pins;
        s_rd(8'hc0) |=> s_data ##0 ans_data[31:7] == 25'h0;
    endproperty
    property p_out_dev;
        s_rd(8'h80) |=> s_data ##0 (ans_data & ~32'h01fe_8d89) == 32'h0;
    endproperty
    property p_comm_rd;
        s_rd(8'h60) |=> s_data ##0 ans_data == (last_wr_r & 32'hefff_1c7f);
    endproperty
    property p_wr_ack;
        wr_hit |=> ans_valid && ans_kind == iosc_pkg::IOSC_ANS_ACK;
    endproperty
    property p_dis_ack;
        s_dis(16'h1ea5) |=> ans_kind == iosc_pkg::IOSC_ANS_ACK;
    endproperty
    property p_bad_key;
        req_valid && req_cmd == 8'h90 && req_data[15:0] != 16'h1ea5 |=> ans_kind == iosc_pkg::IOSC_ANS_ERR;
    endproperty

    a_ans_lat:   assert property (p_ans_lat)   else $error("answer missing after request");
    a_no_stray:  assert property (p_no_stray)  else $error("answer without request");
    a_in_pins:   assert property (p_in_pins)   else $error("input pin reply bad");
    a_out_pins:  assert property (p_out_pins)  else $error("output pin reply bad");
    a_out_dev:   assert property (p_out_dev)   else $error("output device reply bad");
    a_comm_rd:   assert property (p_comm_rd)   else $error("input device reply bad");
    a_wr_ack:    assert property (p_wr_ack)    else $error("device write not acked");
    a_dis_ack:   assert property (p_dis_ack)   else $error("disable not acked");
    a_bad_key:   assert property (p_bad_key)   else $error("wrong key accepted");
endmodule : iosc_link_asserts

// >>> dv/tb.sv
// testbench: apb-driven master end and device end joined over the link
`timescale 1ns/1ps
module tb;
    logic        i_sys_clk;
    logic        i_rst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [9:0]  in_pins;
    logic [6:0]  out_pins;
    logic [31:0] ext_in_dev;
    logic [31:0] out_dev;
    logic [15:0] analog;
    logic        pulse;
    logic [31:0] eff_in_dev;
    logic [15:0] eff_analog;
    logic        eff_pulse;
    logic        in_disabled;
    logic [31:0] rdata;
    logic        err_r;
    int          mismatches;
    int          total_checks;
    int          cycles;

    iosc_if u_iosc_if ();
    iosc_master u_iosc_master (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .link(u_iosc_if), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr));
    iosc_device u_iosc_device (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .link(u_iosc_if),
        .i_ext_in_pins(in_pins), .i_ext_out_pins(out_pins), .i_ext_in_dev(ext_in_dev), .i_out_dev(out_dev),
        .i_analog_in(analog), .i_pulse_in(pulse), .o_eff_in_dev(eff_in_dev), .o_eff_analog(eff_analog),
        .o_eff_pulse(eff_pulse), .o_in_disabled(in_disabled));
    iosc_link_asserts u_iosc_link_asserts (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
        .req_valid(u_iosc_if.req_valid), .req_cmd(u_iosc_if.req_cmd), .req_dnum(u_iosc_if.req_dnum),
        .req_data(u_iosc_if.req_data), .ans_valid(u_iosc_if.ans_valid), .ans_kind(u_iosc_if.ans_kind),
        .ans_data(u_iosc_if.ans_data));

    // ==========================================
    // shared tasks
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge i_sys_clk);
        penable <= 1'b1;
        @(posedge i_sys_clk);
        while (pready !== 1'b1)
            @(posedge i_sys_clk);
        rdata = prdata;
        err_r = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // launch one link command, wait for done, judge kind and answer
    task automatic cmd(input logic [15:0] op, input logic [31:0] d, input logic [1:0] k, input logic [31:0] exp);
        apb(1'b1, 12'h004, d);
        apb(1'b1, 12'h000, {16'h0000, op});
        rdata = 32'h0;
        while (rdata[1] !== 1'b1 || rdata[0] !== 1'b0)
            apb(1'b0, 12'h008, 32'h0);
        chk_word({30'h0, rdata[3:2]}, {30'h0, k});
        apb(1'b0, 12'h00c, 32'h0);
        chk_word(rdata, exp);
        repeat (2) @(posedge i_sys_clk);
    endtask : cmd

    // ==========================================
    // scenarios
    task automatic t_status_reads;
        @(posedge i_sys_clk);
        in_pins <= 10'h2a5;
        out_pins <= 7'h5a;
        out_dev <= 32'hffff_ffff;
        repeat (3) @(posedge i_sys_clk);
        cmd(16'h1240, 32'h0, 2'b01, 32'h0000_02a5);
        cmd(16'h12c0, 32'h0, 2'b01, 32'h0000_005a);
        cmd(16'h1280, 32'h0, 2'b01, 32'h01fe_8d89);
    endtask : t_status_reads

    task automatic t_dev_write;
        cmd(16'h9260, 32'hffff_ffff, 2'b11, 32'h0);
        cmd(16'h1260, 32'h0, 2'b01, 32'hefff_1c7f);
        chk_word(eff_in_dev, 32'hefff_1c7f);
        cmd(16'h9260, 32'h0001_0807, 2'b11, 32'h0);
        cmd(16'h1260, 32'h0, 2'b01, 32'h0001_0807);
        ext_in_dev <= 32'h0000_0001;
        cmd(16'h9260, 32'h0001_0806, 2'b11, 32'h0);
        chk_word(eff_in_dev, 32'h0001_0807);
        ext_in_dev <= 32'h0000_0000;
        repeat (4) @(posedge i_sys_clk);
        chk_word(eff_in_dev, 32'h0001_0806);
    endtask : t_dev_write

    task automatic t_disable;
        @(posedge i_sys_clk);
        analog <= 16'h1234;
        pulse <= 1'b1;
        cmd(16'h9000, 32'h0000_1ea4, 2'b10, 32'h0);
        chk_word({31'h0, in_disabled}, 32'h0);
        cmd(16'h9000, 32'h0000_1ea5, 2'b11, 32'h0);
        chk_word({31'h0, in_disabled}, 32'h1);
        chk_word(eff_in_dev, 32'h0001_0006);
        chk_word({15'h0, eff_analog, eff_pulse}, 32'h0);
        cmd(16'h1260, 32'h0, 2'b01, 32'h0001_0806);
        cmd(16'h9010, 32'h0000_1ea5, 2'b11, 32'h0);
        chk_word({15'h0, eff_analog, eff_pulse}, {15'h0, 16'h1234, 1'b1});
        chk_word(eff_in_dev, 32'h0001_0806);
        chk_word({31'h0, in_disabled}, 32'h0);
    endtask : t_disable

    task automatic t_unmapped;
        apb(1'b0, 12'h010, 32'h0);
        chk_word({rdata[30:0], err_r}, 32'h1);
        apb(1'b0, 12'h000, 32'h0);
        chk_word(rdata, 32'h0000_9010);
        apb(1'b0, 12'h004, 32'h0);
        chk_word(rdata, 32'h0000_1ea5);
    endtask : t_unmapped

    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    // ==========================================
    // clock, timeout and main sequence
    initial
    begin
        i_sys_clk = 1'b0;
        forever #2 i_sys_clk = ~i_sys_clk;
    end

    always @(posedge i_sys_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            complete_run();
        end
    end

    initial
    begin
        {i_rst_n, psel, penable, pwrite, pulse} = 5'h0;
        {paddr, pwdata, in_pins, out_pins, ext_in_dev, out_dev, analog} = '0;
        repeat (4) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        t_status_reads();
        t_dev_write();
        t_disable();
        t_unmapped();
        complete_run();
    end
endmodule : tb
